// File: logic/spss_pkg.sv
// Constants, register map and types of the sensor power saving sequencer
// Summary of operation
// RULE1: Abort by stop or config discards results
// RULE2: Power-up delay runs before wake-up delay
// RULE3: Reset leaves device in power-off state
// RULE4: Power-off stops clock, registers stay reachable
// RULE5: Power-down request waits for conversion end
// RULE6: Clearing power-down starts timed power-up
// RULE7: Power-off start also via bit/edge, delayed
// RULE8: Single/trigger return to power-off; free-running continues
// RULE9: Host writes 02h, 03h, 80h in order
// RULE10: Power-off leaves only on start condition
// RULE11: Ready falls when programmed measurement starts
// RULE12: Standby adds wake-up delay after power-up
// RULE13: Saving state applied after store or abort
// RULE14: Standby bit changes only in configuration
// RULE15: Start condition leaves standby, then converts
// RULE16: Single-shot end clears start/stop bit
// RULE17: Edge mode ignores edges while busy
// RULE18: Triggers ignored in configuration and pause
// RULE19: Ready follows the real conversion only
// RULE20: Standby held during pause when enabled
// RULE21: Host sets pause long enough to read
// RULE22: Field 011b measures, 000b leaves state unchanged
// RULE23: Ready rises at conversion end, results valid
// RULE24: Bit 7 start/stop, bit 6 power-down, 2:0 field
package spss_pkg;
    // ****************************************
    // Register map and fields
    // ****************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_OSR = 8'h00;
    localparam logic [7:0] OFS_CFG3 = 8'h04;
    localparam logic [7:0] OFS_BREAK = 8'h08;
    localparam logic [7:0] OFS_CONV = 8'h0C;
    localparam logic [7:0] OFS_EDGES = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam int BIT_SS = 7;
    localparam int BIT_PD = 6;
    localparam int BIT_SB = 0;
    localparam logic [2:0] DOS_NOP = 3'h0;
    localparam logic [2:0] DOS_CONFIG = 3'h2;
    localparam logic [2:0] DOS_MEAS = 3'h3;
    localparam logic [7:0] RST_BREAK = 8'h19;
    localparam logic [15:0] RST_CONV = 16'h0040;
    localparam logic [7:0] RST_EDGES = 8'h01;

    // ****************************************
    // Timing
    // ****************************************
    localparam int TMR_W = 24;
    localparam int CLK_PERIOD_NS = 8;
    localparam int STARTUP_PD_NS = 1200000;
    localparam int WAKE_SB_NS = 4000;
    localparam int BREAK_STEP_NS = 8000;
    localparam int CONV_UNIT_NS = 1000;
    localparam int STARTUP_PD_CYC = (STARTUP_PD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [TMR_W-1:0] WAKE_SB_CYC = TMR_W'((WAKE_SB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] BREAK_STEP_CYC = TMR_W'(BREAK_STEP_NS / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] CONV_UNIT_CYC = TMR_W'(CONV_UNIT_NS / CLK_PERIOD_NS);

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        MODE_FREE_RUNNING_MODE = 2'h0,
        MODE_CMD = 2'h1,
        MODE_EDGE_TRIGGERED_MODE = 2'h2,
        MODE_GATED_WINDOW_MODE = 2'h3
    } spss_mode_t;

    typedef enum logic [6:0] {
        ST_PWR_OFF = 7'h01,
        ST_STARTUP = 7'h02,
        ST_WAKE = 7'h04,
        ST_IDLE = 7'h08,
        ST_STANDBY = 7'h10,
        ST_CONV = 7'h20,
        ST_PAUSE = 7'h40
    } spss_state_t;
endpackage

// File: logic/spss_sequencer.sv
// Power saving sequencer of the light sensor core with APB registers
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ns
module spss_sequencer #(
    parameter int unsigned STARTUP_CYCLES = spss_pkg::STARTUP_PD_CYC
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [spss_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic trigger_input,
    output logic ready_out,
    output logic clk_gen_en,
    output logic analog_standby,
    output logic result_store,
    output logic result_discard
);
    import spss_pkg::*;

    // ****************************************
    // Elaboration checks
    // ****************************************
    if (STARTUP_CYCLES < 1 || STARTUP_CYCLES >= (1 << TMR_W)) begin : g_chk
        $error("STARTUP_CYCLES out of timer range");
    end

    localparam logic [TMR_W-1:0] STARTUP_CNT = TMR_W'(STARTUP_CYCLES);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        spss_state_t state;
        logic ss;
        logic pd;
        logic meas;
        logic sb;
        spss_mode_t mode;
        logic [7:0] brk;
        logic [15:0] conversion_time;
        logic [7:0] edges;
        logic go;
        logic [7:0] edge_cnt;
        logic tmr_load;
        logic [TMR_W-1:0] tmr_count;
        logic ready;
        logic clk_en;
        logic sb_en;
        logic store;
        logic discard;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
        logic trig_s1;
        logic trig_s2;
        logic trig_s3;
    } spss_st_t;

    spss_st_t r_ff;
    spss_st_t nxt_r;

    spss_tmr_if ti ();

    spss_timer u_timer (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .ti(ti)
    );

    assign ti.load = r_ff.tmr_load;
    assign ti.count = r_ff.tmr_count;

    // ****************************************
    // Helpers
    // ****************************************
    // Value times unit in cycles, saturating so a huge setting never wraps short
    function automatic logic [TMR_W-1:0] to_cyc(input logic [15:0] v, input logic [TMR_W-1:0] unit);
        logic [39:0] p;
        p = 40'(v) * 40'(unit);
        if (p[39:TMR_W] != '0) begin
            to_cyc = '1;
        end else begin
            to_cyc = p[TMR_W-1:0];
        end
    endfunction

    // Resting state once a measurement ends or is abandoned
    function automatic spss_state_t rest_state(input logic pd, input logic sb);
        if (pd) begin
            rest_state = ST_PWR_OFF;
        end else if (sb) begin
            rest_state = ST_STANDBY;
        end else begin
            rest_state = ST_IDLE;
        end
    endfunction

    function automatic logic [31:0] read_word(input spss_st_t s, input logic [ADDR_W-1:0] a);
        read_word = '0;
        unique case (a)
            OFS_OSR: begin
                read_word[BIT_SS] = s.ss; // RULE24
                read_word[BIT_PD] = s.pd;
                read_word[2:0] = s.meas ? DOS_MEAS : DOS_CONFIG;
            end
            OFS_CFG3: begin
                read_word[BIT_SB] = s.sb;
                read_word[2:1] = s.mode;
            end
            OFS_BREAK: read_word[7:0] = s.brk;
            OFS_CONV: read_word[15:0] = s.conversion_time;
            OFS_EDGES: read_word[7:0] = s.edges;
            OFS_STATUS: read_word[7:0] = {s.ready, s.state};
            default: read_word = '0;
        endcase
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = (a == OFS_OSR) || (a == OFS_CFG3) || (a == OFS_BREAK) ||
            (a == OFS_CONV) || (a == OFS_EDGES) || (a == OFS_STATUS);
    endfunction

    // ****************************************
    // Next-state logic
    // ****************************************
    logic trig_fall;
    logic start_ok;
    logic wr;
    logic abort;

    always_comb begin
        nxt_r = r_ff;
        nxt_r.tmr_load = 1'b0;
        nxt_r.store = 1'b0;
        nxt_r.discard = 1'b0;
        // Pin passes two flops before the edge detector looks at it
        nxt_r.trig_s1 = trigger_input;
        nxt_r.trig_s2 = r_ff.trig_s1;
        nxt_r.trig_s3 = r_ff.trig_s2;
        trig_fall = r_ff.trig_s3 && !r_ff.trig_s2;
        // Only resting states look at a start; configuration ignores triggers
        start_ok = r_ff.meas && r_ff.ss && (!r_ff.mode[1] || trig_fall); // RULE18
        abort = !r_ff.ss || !r_ff.meas;
        wr = psel && penable && r_ff.pready && pwrite;

        // APB: answer in the first access cycle, one wait-free access
        if (psel && !penable) begin
            nxt_r.pready = 1'b1;
            nxt_r.prdata = read_word(r_ff, paddr);
            nxt_r.pslverr = !mapped(paddr);
        end else if (psel && penable && r_ff.pready) begin
            nxt_r.pready = 1'b0;
            nxt_r.pslverr = 1'b0;
        end

        unique case (r_ff.state)
            // Clock and analog off; registers still served on the bus
            ST_PWR_OFF: begin
                if (!r_ff.pd) begin
                    nxt_r.state = ST_STARTUP; // RULE6
                    nxt_r.go = 1'b0;
                    nxt_r.tmr_load = 1'b1;
                    nxt_r.tmr_count = STARTUP_CNT;
                end else if (start_ok) begin
                    nxt_r.state = ST_STARTUP; // RULE7 RULE10
                    nxt_r.go = 1'b1;
                    nxt_r.tmr_load = 1'b1;
                    nxt_r.tmr_count = STARTUP_CNT;
                end
            end
            ST_STARTUP: begin
                if (ti.done) begin
                    if (r_ff.go && !abort) begin
                        // Wake-up delay only after the power-up delay
                        if (r_ff.sb) begin
                            nxt_r.state = ST_WAKE; // RULE2 RULE12
                            nxt_r.tmr_load = 1'b1;
                            nxt_r.tmr_count = WAKE_SB_CYC;
                        end else begin
                            nxt_r.state = ST_CONV;
                            nxt_r.edge_cnt = '0;
                            nxt_r.tmr_load = 1'b1;
                            nxt_r.tmr_count = to_cyc(r_ff.conversion_time, CONV_UNIT_CYC);
                        end
                    end else begin
                        nxt_r.state = r_ff.pd ? ST_PWR_OFF : (r_ff.sb ? ST_STANDBY : ST_IDLE); // RULE6
                    end
                    nxt_r.go = 1'b0;
                end
            end
            ST_WAKE: begin
                if (ti.done) begin
                    if (abort) begin
                        nxt_r.state = rest_state(r_ff.pd, r_ff.sb);
                    end else begin
                        nxt_r.state = ST_CONV; // RULE15
                        nxt_r.edge_cnt = '0;
                        nxt_r.tmr_load = 1'b1;
                        nxt_r.tmr_count = to_cyc(r_ff.conversion_time, CONV_UNIT_CYC);
                    end
                end
            end
            ST_IDLE, ST_STANDBY: begin
                if (start_ok) begin
                    if (r_ff.state == ST_STANDBY) begin
                        nxt_r.state = ST_WAKE; // RULE15
                        nxt_r.tmr_load = 1'b1;
                        nxt_r.tmr_count = WAKE_SB_CYC;
                    end else begin
                        nxt_r.state = ST_CONV;
                        nxt_r.edge_cnt = '0;
                        nxt_r.tmr_load = 1'b1;
                        nxt_r.tmr_count = to_cyc(r_ff.conversion_time, CONV_UNIT_CYC);
                    end
                end else begin
                    nxt_r.state = rest_state(r_ff.pd, r_ff.sb);
                end
            end
            // Edges seen here are counted in every mode; only the gated mode stops on them
            ST_CONV: begin
                if (abort) begin
                    nxt_r.state = rest_state(r_ff.pd, r_ff.sb); // RULE1 RULE13
                    nxt_r.discard = 1'b1;
                end else if ((r_ff.mode == MODE_GATED_WINDOW_MODE) ? (trig_fall && r_ff.edge_cnt + 8'h01 >= r_ff.edges)
                        : ti.done) begin
                    nxt_r.store = 1'b1; // RULE13
                    if (r_ff.mode == MODE_CMD) begin
                        nxt_r.ss = 1'b0; // RULE16
                        nxt_r.state = rest_state(r_ff.pd, r_ff.sb); // RULE5 RULE8
                    end else begin
                        nxt_r.state = ST_PAUSE;
                        nxt_r.tmr_load = 1'b1;
                        nxt_r.tmr_count = to_cyc({8'h00, r_ff.brk}, BREAK_STEP_CYC);
                    end
                end else if (trig_fall) begin
                    nxt_r.edge_cnt = r_ff.edge_cnt + 8'h01; // RULE17
                end
            end
            // Trigger edges fall on deaf ears during the pause
            ST_PAUSE: begin
                if (abort) begin
                    nxt_r.state = rest_state(r_ff.pd, r_ff.sb); // RULE18
                end else if (ti.done) begin
                    if (r_ff.mode == MODE_FREE_RUNNING_MODE) begin
                        // Free-running keeps going even with power-down set
                        if (r_ff.sb) begin
                            nxt_r.state = ST_WAKE; // RULE8
                            nxt_r.tmr_load = 1'b1;
                            nxt_r.tmr_count = WAKE_SB_CYC;
                        end else begin
                            nxt_r.state = ST_CONV;
                            nxt_r.edge_cnt = '0;
                            nxt_r.tmr_load = 1'b1;
                            nxt_r.tmr_count = to_cyc(r_ff.conversion_time, CONV_UNIT_CYC);
                        end
                    end else begin
                        nxt_r.state = rest_state(r_ff.pd, r_ff.sb); // RULE8
                    end
                end
            end
        endcase

        // Register writes; a bus write lands after the hardware clear of start/stop
        if (wr) begin
            unique case (paddr)
                OFS_OSR: begin
                    nxt_r.ss = pwdata[BIT_SS];
                    nxt_r.pd = pwdata[BIT_PD];
                    if (pwdata[2:0] == DOS_MEAS) begin
                        nxt_r.meas = 1'b1; // RULE22
                    end else if (pwdata[2:0] == DOS_CONFIG) begin
                        nxt_r.meas = 1'b0;
                    end
                end
                OFS_CFG3: begin
                    if (!r_ff.meas) begin
                        nxt_r.sb = pwdata[BIT_SB]; // RULE14
                        nxt_r.mode = spss_mode_t'(pwdata[2:1]);
                    end
                end
                OFS_BREAK: nxt_r.brk = pwdata[7:0];
                OFS_CONV: nxt_r.conversion_time = pwdata[15:0];
                OFS_EDGES: nxt_r.edges = pwdata[7:0];
                default: nxt_r.ss = nxt_r.ss;
            endcase
        end

        // Outputs follow the next state so each pin is a plain flop
        nxt_r.ready = (nxt_r.state != ST_CONV); // RULE11 RULE19 RULE23
        nxt_r.clk_en = (nxt_r.state != ST_PWR_OFF); // RULE4
        nxt_r.sb_en = (nxt_r.state == ST_STANDBY) || (nxt_r.state == ST_PAUSE && r_ff.sb); // RULE20
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            r_ff <= '0;
            r_ff.state <= ST_PWR_OFF; // RULE3
            r_ff.pd <= 1'b1;
            r_ff.mode <= MODE_CMD;
            r_ff.brk <= RST_BREAK;
            r_ff.conversion_time <= RST_CONV;
            r_ff.edges <= RST_EDGES;
            r_ff.ready <= 1'b1;
            r_ff.trig_s1 <= 1'b1;
            r_ff.trig_s2 <= 1'b1;
            r_ff.trig_s3 <= 1'b1;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign prdata = r_ff.prdata;
    assign pready = r_ff.pready;
    assign pslverr = r_ff.pslverr;
    assign ready_out = r_ff.ready;
    assign clk_gen_en = r_ff.clk_en;
    assign analog_standby = r_ff.sb_en;
    assign result_store = r_ff.store;
    assign result_discard = r_ff.discard;
endmodule

// File: logic/spss_timer.sv
// Down-counting delay timer with one-cycle done pulse
`timescale 1ns/1ns
module spss_timer (
    input wire logic sys_clk,
    input wire logic resetn,
    spss_tmr_if.tmr ti
);
    import spss_pkg::*;

    typedef struct packed {
        logic run;
        logic [TMR_W-1:0] cnt;
        logic done;
    } spss_tmr_st_t;

    spss_tmr_st_t r_ff;
    spss_tmr_st_t nxt_r;

    // Load restarts the count; a zero count is treated as one cycle
    always_comb begin
        nxt_r = r_ff;
        nxt_r.done = 1'b0;
        if (ti.load) begin
            nxt_r.run = 1'b1;
            nxt_r.cnt = (ti.count == '0) ? TMR_W'(1) : ti.count;
        end else if (r_ff.run) begin
            nxt_r.cnt = r_ff.cnt - TMR_W'(1);
            if (r_ff.cnt == TMR_W'(1)) begin
                nxt_r.run = 1'b0;
                nxt_r.done = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign ti.done = r_ff.done;
endmodule

// File: logic/spss_tmr_if.sv
// Interface between the sequencer and its delay timer
`timescale 1ns/1ns
interface spss_tmr_if;
    import spss_pkg::*;
    logic load;
    logic [TMR_W-1:0] count;
    logic done;
    modport ctl (output load, output count, input done);
    modport tmr (input load, input count, output done);
endinterface

// File: verification/spss_props.sv
// Port-level property checker for the power saving sequencer
`timescale 1ns/1ns
module spss_props #(
    parameter int unsigned STARTUP_CYCLES = 20
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ready_out,
    input wire logic clk_gen_en,
    input wire logic analog_standby,
    input wire logic result_store,
    input wire logic result_discard
);
    // ****************
    // Helper counter
    // ****************
    logic [31:0] on_cnt_ff;
    logic [31:0] nxt_on_cnt;

    // Clock-on cycles, saturating so idle starts are not penalised
    always_comb begin
        nxt_on_cnt = on_cnt_ff;
        if (!clk_gen_en) begin
            nxt_on_cnt = '0;
        end else if (on_cnt_ff < 32'(STARTUP_CYCLES - 1)) begin
            nxt_on_cnt = on_cnt_ff + 32'h1;
        end
    end

    // Helper register
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            on_cnt_ff <= '0;
        end else begin
            on_cnt_ff <= nxt_on_cnt;
        end
    end

    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    sequence setup_s;
        psel && !penable;
    endsequence
    sequence conv_end_s;
        $rose(ready_out);
    endsequence
    sequence wake_s;
        $fell(analog_standby) ##0 ready_out;
    endsequence

    apb_answer_a: assert property (setup_s |=> pready)
        else $error("no answer after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    err_qualified_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    store_at_end_a: assert property (result_store |-> conv_end_s)
        else $error("store without ready rising");
    abort_discard_a: assert property (result_discard |-> !result_store && $past(!ready_out))
        else $error("discard outside an aborted conversion");
    conv_clock_on_a: assert property (!ready_out |-> clk_gen_en)
        else $error("converting with clock stopped");
    startup_span_a: assert property ($fell(ready_out) |-> on_cnt_ff == 32'(STARTUP_CYCLES - 1))
        else $error("conversion before startup span");
    standby_quiet_a: assert property (analog_standby |-> ready_out && clk_gen_en)
        else $error("standby while converting or off");
    wake_delay_a: assert property (wake_s |=> ready_out [*8])
        else $error("conversion without wake-up delay");
endmodule

// File: verification/spss_sequencer_tb_top.sv
// Self-checking bench for the power saving sequencer
`timescale 1ns/1ns
module spss_sequencer_tb_top;
    import spss_pkg::*;
    localparam int unsigned NSTART = 20;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic trigger_input;
    logic ready_out;
    logic clk_gen_en;
    logic analog_standby;
    logic result_store;
    logic result_discard;
    logic [31:0] rdat;
    logic rerr;
    logic ready_q = 1'b1;
    int mismatches = 0;
    int num_checks = 0;
    int stores = 0;
    int discards = 0;
    int falls = 0;
    int n;
    int s;
    int d;
    int f;

    // ****************
    // Clock, design and partner
    // ****************
    always #4 sys_clk = ~sys_clk;

    spss_sequencer #(.STARTUP_CYCLES(NSTART)) u_dut (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .trigger_input(trigger_input), .ready_out(ready_out),
        .clk_gen_en(clk_gen_en), .analog_standby(analog_standby), .result_store(result_store),
        .result_discard(result_discard));
    spss_trig_src u_trig (.sys_clk(sys_clk), .trigger_input(trigger_input));

    // Event counters sample on the falling edge, clear of the launch edge
    always @(negedge sys_clk) begin
        if (result_store === 1'b1) stores++;
        if (result_discard === 1'b1) discards++;
        if (ready_q === 1'b1 && ready_out === 1'b0) falls++;
        ready_q = ready_out;
    end

    // ****************
    // Tasks
    // ****************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; the slave's answer time is never assumed
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dat);
        int k;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= dat;
        @(posedge sys_clk);
        penable <= 1'b1;
        k = 0;
        // Look mid-cycle so the answer is read while it stands, not in its launch step
        @(negedge sys_clk);
        while (pready !== 1'b1 && k < 50) begin
            @(negedge sys_clk);
            k++;
        end
        chk(32'(k < 50), 32'h1);
        rdat = prdata;
        rerr = pslverr;
        // Release only after the edge that sees pready high
        @(posedge sys_clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        apb(1'b1, a, dat);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask

    task automatic wait_rdy(input logic v, output int cnt);
        cnt = 0;
        while (ready_out !== v && cnt < 5000) begin
            @(negedge sys_clk);
            cnt++;
        end
    endtask

    // ****************
    // Scenarios
    // ****************
    task automatic t_reset();
        chk(32'(clk_gen_en), 32'h0);
        rd(OFS_STATUS, 32'h81);
        rd(OFS_OSR, 32'h42);
        rd(8'h20, 32'h0);
        chk(32'(rerr), 32'h1);
        wr(OFS_BREAK, 32'h1);
        wr(OFS_CONV, 32'h1);
        rd(OFS_CONV, 32'h1);
    endtask

    // Separated startup, then one single-shot from idle
    task automatic t_separated();
        wr(OFS_OSR, 32'h2);
        rd(OFS_STATUS, 32'h82);
        repeat (NSTART + 10) @(posedge sys_clk);
        rd(OFS_STATUS, 32'h88);
        wr(OFS_OSR, 32'h3);
        wr(OFS_CFG3, 32'h3);
        rd(OFS_CFG3, 32'h2);
        s = stores;
        wr(OFS_OSR, 32'h80);
        wait_rdy(1'b0, n);
        chk(32'(n < 5), 32'h1);
        wait_rdy(1'b1, n);
        chk(32'(n >= 120 && n <= 135), 32'h1);
        repeat (2) @(posedge sys_clk);
        chk(32'(stores - s), 32'h1);
        rd(OFS_OSR, 32'h3);
    endtask

    // Power-off start with standby: both delays in a row
    task automatic t_pd_sb();
        wr(OFS_OSR, 32'h42);
        repeat (50) @(posedge sys_clk);
        chk(32'(clk_gen_en), 32'h0);
        wr(OFS_CFG3, 32'h3);
        rd(OFS_CFG3, 32'h3);
        wr(OFS_OSR, 32'hC3);
        wait_rdy(1'b0, n);
        chk(32'(n >= NSTART + 500 && n <= NSTART + 530), 32'h1);
        wait_rdy(1'b1, n);
        repeat (5) @(posedge sys_clk);
        chk(32'(clk_gen_en), 32'h0);
        rd(OFS_OSR, 32'h43);
    endtask

    // Free-running with standby in the pause, then aborted mid-conversion
    task automatic t_abort();
        wr(OFS_OSR, 32'h2);
        wr(OFS_CFG3, 32'h1);
        repeat (NSTART + 10) @(posedge sys_clk);
        chk(32'(analog_standby), 32'h1);
        wr(OFS_OSR, 32'h83);
        wait_rdy(1'b0, n);
        chk(32'(n >= 495 && n <= 520), 32'h1);
        wait_rdy(1'b1, n);
        repeat (20) @(posedge sys_clk);
        chk(32'(analog_standby), 32'h1);
        wait_rdy(1'b0, n);
        chk(32'(n >= 1470 && n <= 1530), 32'h1);
        s = stores;
        d = discards;
        wr(OFS_OSR, 32'h3);
        repeat (5) @(posedge sys_clk);
        chk(32'(ready_out), 32'h1);
        chk(32'(discards - d), 32'h1);
        chk(32'(stores - s), 32'h0);
        f = falls;
        repeat (1600) @(posedge sys_clk);
        chk(32'(falls - f), 32'h0);
    endtask

    // Power-down requested mid-conversion waits for the end
    task automatic t_pd_during();
        wr(OFS_OSR, 32'h2);
        wr(OFS_CFG3, 32'h2);
        wr(OFS_OSR, 32'h83);
        wait_rdy(1'b0, n);
        s = stores;
        d = discards;
        wr(OFS_OSR, 32'hC0);
        wait_rdy(1'b1, n);
        repeat (5) @(posedge sys_clk);
        chk(32'(stores - s), 32'h1);
        chk(32'(discards - d), 32'h0);
        chk(32'(clk_gen_en), 32'h0);
    endtask

    // Edge-triggered: edges in configuration, conversion and pause ignored
    task automatic t_edge();
        wr(OFS_OSR, 32'h2);
        wr(OFS_CFG3, 32'h4);
        f = falls;
        u_trig.pulse();
        repeat (NSTART + 50) @(posedge sys_clk);
        chk(32'(falls - f), 32'h0);
        wr(OFS_OSR, 32'h83);
        repeat (20) @(posedge sys_clk);
        chk(32'(falls - f), 32'h0);
        u_trig.pulse();
        wait_rdy(1'b0, n);
        u_trig.pulse();
        wait_rdy(1'b1, n);
        repeat (50) @(posedge sys_clk);
        u_trig.pulse();
        repeat (1100) @(posedge sys_clk);
        chk(32'(falls - f), 32'h1);
        u_trig.pulse();
        repeat (20) @(posedge sys_clk);
        chk(32'(falls - f), 32'h2);
        wait_rdy(1'b1, n);
    endtask

    task automatic results();
        if (mismatches == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        t_reset();
        t_separated();
        t_pd_sb();
        t_abort();
        t_pd_during();
        t_edge();
        results();
    end

    // Watchdog, about four times the expected run
    initial begin
        #200000;
        mismatches++;
        results();
    end
endmodule

bind spss_sequencer spss_props #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_props (.sys_clk(sys_clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .ready_out(ready_out),
    .clk_gen_en(clk_gen_en), .analog_standby(analog_standby), .result_store(result_store),
    .result_discard(result_discard));

// File: verification/spss_trig_src.sv
// Trigger pulse source standing in for the external trigger driver
`timescale 1ns/1ns
module spss_trig_src (
    input wire logic sys_clk,
    output logic trigger_input
);
    // Pin idles high; only its falling edges matter
    initial trigger_input = 1'b1;

    // Low for four cycles so the two-flop synchroniser cannot miss it
    task automatic pulse();
        @(posedge sys_clk);
        trigger_input <= 1'b0;
        repeat (4) @(posedge sys_clk);
        trigger_input <= 1'b1;
    endtask
endmodule
